// ===== core/vipe_pkg.sv
package vipe_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00; // enables, levels, selects
	localparam logic [7:0] OFS_PEND    = 8'h04; // pending: sw bits writable
	localparam logic [7:0] OFS_MASK    = 8'h08; // int_mask
	localparam logic [7:0] OFS_STATE   = 8'h0c; // live dispatch state
	localparam logic [7:0] OFS_SRSMAP0 = 8'h10; // shadow sets, vectors 0..7
	localparam logic [7:0] OFS_SRSMAP1 = 8'h14; // shadow sets, vectors 8..9
	localparam logic [7:0] OFS_EVSTAT  = 8'h18; // sticky events, w1c
	localparam logic [7:0] OFS_EVMASK  = 8'h1c; // event mask
	localparam logic [7:0] OFS_FEATURE = 8'h20; // feature_config_word, ro
	// ----------------------------------------
	// widths, positions, reset values
	// ----------------------------------------
	localparam int         NSRC      = 10;     // sources, vector = index
	localparam int         NHW       = 8;      // hardware lines
	localparam int         NSW       = 2;      // software requests
	localparam int         SS_W      = 4;      // shadow set number width
	localparam int         NEV       = 2;      // event bits
	localparam int         EV_SIG    = 0;      // signaled rising edge
	localparam int         EV_VEC    = 1;      // vector changed while signaled
	localparam int         FT_VECTORED_INT_IMPLEMENTED   = 0;      // feature: vectored implemented
	localparam int         FT_EXT_CONTROLLER_IMPLEMENTED   = 1;      // feature: ext controller
	localparam int         FT_TLINE  = 2;      // feature: timer_int_line lsb
	localparam logic [9:0] CTRL_RST  = 10'h010; // boot_vector_select set
	localparam logic [9:0] OFS_COMPAT0 = 10'h180; // compat, select 0
	localparam logic [9:0] OFS_COMPAT1 = 10'h200; // compat, select 1
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [4:0] vector_spacing;
		logic       boot_vector_select;
		logic       int_vector_select;
		logic       error_level;
		logic       exception_level;
		logic       global_int_enable;
	} vipe_ctrl_type;
	typedef struct packed {
		logic        signaled;      // interrupt signaled to core
		logic        vectored_mode; // vectored mode in effect
		logic [3:0]  vector;        // valid only while signaled
		logic [3:0]  shadow_set;    // valid while signaled and vectored
		logic [9:0]  offset;        // compat dispatch offset, else 0
	} vipe_disp_type;
endpackage

// ===== core/vipe_top.sv
`timescale 1ns/1ps
// Function
// - vectored mode needs all five conditions
// - each hardware line is its own request
// - request is pending AND mask
// - signal needs request, enable, no exl/erl
// - hw7 highest, vector equals pending index
// - software requests lowest, sw1 above sw0
// - output vector of highest pending request
// - each vector maps to shadow set in vectored mode
// - compat mode dispatch offset 180 or 200
module vipe_top #(
	parameter bit       VECTORED_INT_IMPLEMENTED_IMPL  = 1'b1, // vectored_int_implemented
	parameter bit       EXT_CONTROLLER_IMPLEMENTED_IMPL  = 1'b0, // ext_controller_implemented
	parameter bit [2:0] TIMER_LINE = 3'h7  // hw line carrying the timer
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic [7:0]             hw_int_request,
	output vipe_pkg::vipe_disp_type     disp,
	output logic                        irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	vipe_pkg::vipe_ctrl_type ctrl_ff;        // software control bits
	logic [1:0]              sw_pend_ff;     // sw_int_request
	logic [9:0]              int_mask_ff;    // int_mask
	logic [39:0]             srsmap_ff;      // 4 bits per vector
	logic [1:0]              ev_stat_ff;     // sticky events
	logic [1:0]              ev_mask_ff;     // event mask
	vipe_pkg::vipe_disp_type disp_ff;        // registered dispatch
	logic                    irq_ff;         // interrupt output
	logic                    awready_ff;     // low while an address is held
	logic                    wready_ff;      // low while data is held
	logic                    arready_ff;     // low while a read answer stands
	logic [7:0]              awaddr_ff;
	logic [31:0]             wdata_ff;
	logic [3:0]              wstrb_ff;
	logic                    bvalid_ff;
	logic [1:0]              bresp_ff;
	logic                    rvalid_ff;
	logic [31:0]             rdata_ff;
	logic [1:0]              rresp_ff;
	logic [9:0]              int_pending;    // hw lines over sw bits
	logic [9:0]              req;            // masked requests
	logic                    mode_vec;       // vectored mode condition
	logic                    gate;           // global enable qualified
	vipe_pkg::vipe_disp_type nxt_disp;
	logic                    wr_go;          // both halves held
	logic [31:0]             rd_word;
	logic                    rd_ok;
	logic [1:0]              ev_set;         // events raised this cycle
	logic [1:0]              ev_clr;         // w1c bits written this cycle

	// both implementation options at once is no mode this logic serves
	if (VECTORED_INT_IMPLEMENTED_IMPL && EXT_CONTROLLER_IMPLEMENTED_IMPL)
	begin : g_bad_cfg
		$error("vipe_top: unsupported parameter set");
	end

	// ----------------------------------------
	// request qualification
	// ----------------------------------------
	// hw lines are never decoded as a value, bit n is line n
	assign int_pending = {hw_int_request, sw_pend_ff};
	genvar gi;
	generate
		for (gi = 0; gi < vipe_pkg::NSRC; gi++)
		begin : g_req
			assign req[gi] = int_pending[gi] & int_mask_ff[gi];
		end
	endgenerate

	// all five conditions, spacing nonzero
	assign mode_vec = VECTORED_INT_IMPLEMENTED_IMPL && !EXT_CONTROLLER_IMPLEMENTED_IMPL
		&& (ctrl_ff.vector_spacing != 5'h00)
		&& ctrl_ff.int_vector_select && !ctrl_ff.boot_vector_select;
	assign gate = ctrl_ff.global_int_enable && !ctrl_ff.exception_level
		&& !ctrl_ff.error_level;

	// highest index wins: hw7 first, sw0 last
	function automatic logic [3:0] prio_enc(input logic [9:0] r);
		logic [3:0] v;
		v = 4'h0;
		for (int i = 0; i < vipe_pkg::NSRC; i++)
			if (r[i])
				v = 4'(i);
		return v;
	endfunction

	// next dispatch, from current registers and hw_int_request only
	always_comb
	begin
		nxt_disp = '0;
		nxt_disp.vectored_mode = mode_vec;
		nxt_disp.signaled = (|req) && gate;
		if (nxt_disp.signaled)
		begin
			nxt_disp.vector = prio_enc(req);
			if (mode_vec)
				nxt_disp.shadow_set = srsmap_ff[nxt_disp.vector*4 +: 4];
			else
				nxt_disp.offset = ctrl_ff.int_vector_select ? vipe_pkg::OFS_COMPAT1
					: vipe_pkg::OFS_COMPAT0;
		end
	end

	// recomputed every edge; all but vectored_mode zero when not signaled
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			disp_ff <= '0;
		else
			disp_ff <= nxt_disp;
	end

	// ----------------------------------------
	// axi4-lite write path
	// ----------------------------------------
	assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;

	// address and data taken independently, either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && awready_ff)
			begin
				awready_ff <= 1'b0;
				awaddr_ff  <= s_axi_awaddr;
			end
			else if (wr_go)
				awready_ff <= 1'b1;
			if (s_axi_wvalid && wready_ff)
			begin
				wready_ff <= 1'b0;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			else if (wr_go)
				wready_ff <= 1'b1;
		end
	end

	// response once both halves are in
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= vipe_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (awaddr_ff[7:2] <= vipe_pkg::OFS_EVMASK[7:2])
				? vipe_pkg::RESP_OKAY : vipe_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_ff <= 1'b0;
	end

	// register stores; byte lanes 0 and 1 carry fields, all four lanes for SRSMAP0
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_ff     <= vipe_pkg::CTRL_RST;
			sw_pend_ff  <= 2'h0;
			int_mask_ff <= 10'h000;
			srsmap_ff   <= '0;
			ev_mask_ff  <= 2'h0;
		end
		else if (wr_go)
		begin
			unique case (awaddr_ff)
				vipe_pkg::OFS_CTRL:
					if (wstrb_ff[0])
						ctrl_ff <= wdata_ff[9:0];
				vipe_pkg::OFS_PEND:
					if (wstrb_ff[0])
						sw_pend_ff <= wdata_ff[1:0];
				vipe_pkg::OFS_MASK:
					if (wstrb_ff[0])
						int_mask_ff <= wdata_ff[9:0];
				vipe_pkg::OFS_SRSMAP0:
					srsmap_ff[31:0] <= wdata_ff;
				vipe_pkg::OFS_SRSMAP1:
					if (wstrb_ff[0])
						srsmap_ff[39:32] <= wdata_ff[7:0];
				vipe_pkg::OFS_EVMASK:
					if (wstrb_ff[0])
						ev_mask_ff <= wdata_ff[1:0];
				default:
					;
			endcase
		end
	end

	// ----------------------------------------
	// events and interrupt line
	// ----------------------------------------
	// set beats a simultaneous w1c clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ev_stat_ff <= 2'h0;
		else
			ev_stat_ff <= (ev_stat_ff & ~ev_clr) | ev_set;
	end

	// rise and change both judged against the registered dispatch
	always_comb
	begin
		ev_set = 2'h0;
		ev_set[vipe_pkg::EV_SIG] = nxt_disp.signaled && !disp_ff.signaled;
		ev_set[vipe_pkg::EV_VEC] = nxt_disp.signaled && disp_ff.signaled
			&& (nxt_disp.vector != disp_ff.vector);
	end
	assign ev_clr = (wr_go && awaddr_ff == vipe_pkg::OFS_EVSTAT && wstrb_ff[0])
		? wdata_ff[1:0] : 2'h0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(ev_stat_ff & ev_mask_ff);
	end

	// ----------------------------------------
	// axi4-lite read path
	// ----------------------------------------
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		unique case (s_axi_araddr)
			vipe_pkg::OFS_CTRL:    rd_word[9:0] = ctrl_ff;
			vipe_pkg::OFS_PEND:    rd_word[9:0] = int_pending;
			vipe_pkg::OFS_MASK:    rd_word[9:0] = int_mask_ff;
			vipe_pkg::OFS_STATE:   rd_word[19:0] = disp_ff;
			vipe_pkg::OFS_SRSMAP0: rd_word = srsmap_ff[31:0];
			vipe_pkg::OFS_SRSMAP1: rd_word[7:0] = srsmap_ff[39:32];
			vipe_pkg::OFS_EVSTAT:  rd_word[1:0] = ev_stat_ff;
			vipe_pkg::OFS_EVMASK:  rd_word[1:0] = ev_mask_ff;
			vipe_pkg::OFS_FEATURE:
			begin
				rd_word[vipe_pkg::FT_VECTORED_INT_IMPLEMENTED] = VECTORED_INT_IMPLEMENTED_IMPL;
				rd_word[vipe_pkg::FT_EXT_CONTROLLER_IMPLEMENTED] = EXT_CONTROLLER_IMPLEMENTED_IMPL;
				rd_word[vipe_pkg::FT_TLINE +: 3] = TIMER_LINE;
			end
			default:               rd_ok = 1'b0;
		endcase
	end

	// one read at a time; arready only while idle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= vipe_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_ff)
		begin
			rvalid_ff  <= 1'b1;
			arready_ff <= 1'b0;
			rdata_ff   <= rd_word;
			rresp_ff   <= rd_ok ? vipe_pkg::RESP_OKAY : vipe_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign disp          = disp_ff;
	assign irq           = irq_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_both;
		!awready_ff && !wready_ff && !bvalid_ff;
	endsequence
	sequence s_resp;
		##1 s_axi_bvalid;
	endsequence

	AST_MODE: assert property (
		disp_ff.vectored_mode == $past(VECTORED_INT_IMPLEMENTED_IMPL && !EXT_CONTROLLER_IMPLEMENTED_IMPL
		&& ctrl_ff.vector_spacing != 5'h00 && ctrl_ff.int_vector_select
		&& !ctrl_ff.boot_vector_select))
		else $error("vectored mode mismatch");
	AST_HW_LINE: assert property (
		disp_ff.signaled && disp_ff.vector > 4'h1
		|-> (($past(hw_int_request) >> (disp_ff.vector - 4'h2)) & 8'h01) == 8'h01)
		else $error("vector line not requesting");
	AST_MASKED: assert property (
		disp_ff.signaled |-> (($past(int_mask_ff) >> disp_ff.vector) & 10'h001) == 10'h001)
		else $error("masked source dispatched");
	AST_GATE: assert property (
		$past(!ctrl_ff.global_int_enable || ctrl_ff.exception_level
		|| ctrl_ff.error_level || req == 10'h000) |-> !disp_ff.signaled)
		else $error("signaled while disabled");
	AST_HIGHEST: assert property (
		disp_ff.signaled |-> ($past(req) >> (disp_ff.vector + 4'h1)) == 10'h000)
		else $error("higher request skipped");
	AST_SW_LOW: assert property (
		disp_ff.signaled && disp_ff.vector < 4'h2 |-> $past(req[9:2]) == 8'h00)
		else $error("software beat hardware");
	AST_TAKEN: assert property (
		$past(|req && gate) |-> disp_ff.signaled
		&& (($past(req) >> disp_ff.vector) & 10'h001) == 10'h001)
		else $error("request not encoded");
	AST_SHADOW: assert property (
		disp_ff.signaled && disp_ff.vectored_mode
		|-> disp_ff.shadow_set == 4'($past(srsmap_ff) >> (disp_ff.vector * 4)))
		else $error("shadow set mismatch");
	AST_COMPAT: assert property (
		disp_ff.signaled && !disp_ff.vectored_mode |-> disp_ff.offset ==
		($past(ctrl_ff.int_vector_select) ? vipe_pkg::OFS_COMPAT1 : vipe_pkg::OFS_COMPAT0))
		else $error("compat offset wrong");
	AST_INVALID: assert property (
		!disp_ff.signaled |-> disp_ff.vector == 4'h0 && disp_ff.offset == 10'h000)
		else $error("stale vector");
	AST_BRESP: assert property (s_wr_both |-> s_resp)
		else $error("write not answered");
endmodule

// ===== sim/vipe_src_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// external sources plus timer merge
// ----------------------------------------
module vipe_src_model #(
	parameter bit [2:0] TIMER_LINE = 3'h7 // line that carries the timer
) (
	aclk,
	aresetn,
	line_lvl,
	timer_tick,
	hw_int_request
);
	input  wire logic       aclk;           // core clock
	input  wire logic       aresetn;        // sync reset, active low
	input  wire logic [7:0] line_lvl;       // device levels per line
	input  wire logic       timer_tick;     // timer request level
	output logic      [7:0] hw_int_request; // merged lines to the core

	// registered so lines change only after an edge, like real glue
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			hw_int_request <= 8'h00;
		else
			hw_int_request <= line_lvl | ({7'h00, timer_tick} << TIMER_LINE);
	end
endmodule

// ===== sim/vipe_top_tb.sv
`timescale 1ns/1ps
module vipe_top_tb;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	localparam bit [2:0] TLINE = 3'h7;  // timer merged onto line 7
	logic        aclk = 1'b0;           // 100 ns period
	logic        aresetn = 1'b0;        // held low 3 cycles
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [7:0]  line_lvl = 8'h00;      // partner line levels
	logic        timer_tick = 1'b0;     // partner timer level
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [7:0]  hw_req;
	logic [31:0] r;                     // random draw
	vipe_pkg::vipe_disp_type disp;
	int          error_cnt = 0;
	int          n_compared = 0;
	logic [39:0] srs = 40'h35_9abcdef1; // vector n at [4n+3:4n]
	// enabled, disabled, exl, erl, compat 0x180, boot, zero spacing
	logic [9:0]  ctl_tab [7] = '{10'h029, 10'h028, 10'h02b, 10'h02d, 10'h021, 10'h039, 10'h009};

	always #50 aclk = ~aclk;

	vipe_src_model #(.TIMER_LINE(TLINE)) vipe_src_model_inst (.aclk(aclk), .aresetn(aresetn),
		.line_lvl(line_lvl), .timer_tick(timer_tick), .hw_int_request(hw_req));

	// prot and strobes tied: the design ignores prot
	vipe_top #(.VECTORED_INT_IMPLEMENTED_IMPL(1'b1), .EXT_CONTROLLER_IMPLEMENTED_IMPL(1'b0), .TIMER_LINE(TLINE)) vipe_top_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .hw_int_request(hw_req),
		.disp(disp), .irq(irq));

	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic hang;
		error_cnt++;
		$display("timeout at %0t", $time);
		conclude();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// ----------------------------------------
	// bus master: each channel dropped as soon as taken
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa;
		logic pw;
		int   n;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (pa && awready)
			begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready)
			begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
			if (bvalid)
				break;
		end
		if (n == 50)
			hang();
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		if (n == 50)
			hang();
		rready <= 1'b0;
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// ----------------------------------------
	// expected dispatch from control and qualified requests
	// ----------------------------------------
	function automatic vipe_pkg::vipe_disp_type exp_disp(input logic [9:0] c, input logic [9:0] q);
		vipe_pkg::vipe_ctrl_type cc;
		vipe_pkg::vipe_disp_type e;
		cc = c;
		e = '0;
		// implemented=1, ext controller=0 in this bench
		e.vectored_mode = (cc.vector_spacing != 5'h00) && cc.int_vector_select && !cc.boot_vector_select;
		if ((|q) && cc.global_int_enable && !cc.exception_level && !cc.error_level)
		begin
			e.signaled = 1'b1;
			// ascending scan: the last hit is the highest rank
			for (int k = 0; k < 10; k++)
				if (q[k])
					e.vector = 4'(k);
			if (e.vectored_mode)
				e.shadow_set = srs[4*e.vector +: 4];
			else
				e.offset = c[3] ? vipe_pkg::OFS_COMPAT1 : vipe_pkg::OFS_COMPAT0;
		end
		return e;
	endfunction

	task automatic settle;
		repeat (4) @(posedge aclk);
	endtask

	task automatic apply(input logic [9:0] c, input logic [7:0] lv, input logic tk,
		input logic [1:0] sw, input logic [9:0] mk);
		vipe_pkg::vipe_disp_type e;
		wr(vipe_pkg::OFS_CTRL, {22'h0, c}, vipe_pkg::RESP_OKAY);
		wr(vipe_pkg::OFS_PEND, {30'h0, sw}, vipe_pkg::RESP_OKAY);
		wr(vipe_pkg::OFS_MASK, {22'h0, mk}, vipe_pkg::RESP_OKAY);
		line_lvl <= lv;
		timer_tick <= tk;
		settle();
		e = exp_disp(c, {lv | ({7'h0, tk} << TLINE), sw} & mk);
		chk({12'h0, disp}, {12'h0, e});
		rd(vipe_pkg::OFS_STATE, {12'h0, e}, vipe_pkg::RESP_OKAY);
	endtask

	// run limit
	initial
	begin
		repeat (100000) @(posedge aclk);
		hang();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'haed7));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(vipe_pkg::OFS_CTRL, {22'h0, vipe_pkg::CTRL_RST}, vipe_pkg::RESP_OKAY);
		chk({31'h0, disp.vectored_mode}, 32'h0);
		rd(vipe_pkg::OFS_FEATURE, 32'h1d, vipe_pkg::RESP_OKAY);
		rd(8'h24, 32'h0, vipe_pkg::RESP_SLVERR);
		wr(8'h24, 32'hffff_ffff, vipe_pkg::RESP_SLVERR);
		wr(vipe_pkg::OFS_SRSMAP0, srs[31:0], vipe_pkg::RESP_OKAY);
		wr(vipe_pkg::OFS_SRSMAP1, {24'h0, srs[39:32]}, vipe_pkg::RESP_OKAY);
		$display("test registers done");
		foreach (ctl_tab[i])
			apply(ctl_tab[i], 8'h05, 1'b0, 2'h3, 10'h3ff);
		apply(10'h029, 8'h00, 1'b0, 2'h1, 10'h3ff);
		apply(10'h029, 8'h00, 1'b1, 2'h3, 10'h3fe);
		$display("test gating done");
		// random lines, mask and control, half kept vectored
		for (int i = 0; i < 40; i++)
		begin
			r = $urandom;
			apply(r[31] ? 10'h029 : {5'h01, r[25:21]}, r[7:0], r[8], r[10:9], r[20:11]);
		end
		$display("test random done");
		// sticky event, mask and w1c clear of the interrupt line
		apply(10'h029, 8'h10, 1'b0, 2'h0, 10'h000);
		wr(vipe_pkg::OFS_EVSTAT, 32'h3, vipe_pkg::RESP_OKAY);
		wr(vipe_pkg::OFS_EVMASK, 32'h1, vipe_pkg::RESP_OKAY);
		settle();
		chk({31'h0, irq}, 32'h0);
		wr(vipe_pkg::OFS_MASK, 32'h3ff, vipe_pkg::RESP_OKAY);
		settle();
		chk({31'h0, irq}, 32'h1);
		wr(vipe_pkg::OFS_EVMASK, 32'h0, vipe_pkg::RESP_OKAY);
		settle();
		chk({31'h0, irq}, 32'h0);
		wr(vipe_pkg::OFS_EVMASK, 32'h1, vipe_pkg::RESP_OKAY);
		settle();
		chk({31'h0, irq}, 32'h1);
		wr(vipe_pkg::OFS_EVSTAT, 32'h1, vipe_pkg::RESP_OKAY);
		settle();
		chk({31'h0, irq}, 32'h0);
		$display("test events done");
		conclude();
	end
endmodule
